// *** hw/pim_params.svh ***
`ifndef PIM_PARAMS_SVH
`define PIM_PARAMS_SVH
`define PIM_CLK_MHZ 50
`define PIM_SCAN_NS 900
`define PIM_SCAN_CYC ((`PIM_SCAN_NS * `PIM_CLK_MHZ) / 1000)
`define PIM_GRP_HI 4'h8
`define PIM_OP_EXC 3'h0
`define PIM_OP_XFER 3'h3
`define PIM_FN_LAST_XFER 3'h2
`define PIM_FN_CLR 0
`define PIM_FN_EN 1
`define PIM_FN_DIS 2
`define PIM_DEV_HI 3'h4
`define PIM_MASK_RST 8'h00
`endif

// *** hw/pim_pkg.sv ***
package pim_pkg;
	// Pins sampled from the bus side, all positive sense
	typedef struct packed {
		logic [15:0] bus;
		logic [7:0] lines;
		logic fry;
		logic dry;
		logic ack;
		logic iuc;
		logic jmp;
		logic pri_in;
		logic sysrst;
		logic run;
		logic exec;
		logic [2:0] strap;
		logic [2:0] jumper;
	} pins_t;
	typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_ACK} fsm_t;
	// Whole module state
	typedef struct packed {
		pins_t s1;
		pins_t s2;
		pins_t s3;
		logic [7:0] mask;
		logic [7:0] line_prev;
		logic [7:0] pending;
		logic enable;
		logic dto;
		fsm_t state;
		logic [2:0] served;
		logic [7:0] scan_cnt;
		logic req;
		logic pri_out;
		logic [15:0] bus_out;
		logic bus_oe;
	} st_t;
endpackage

// *** hw/priority_interrupt_module.sv ***
`timescale 1ns/1ns
`include "pim_params.svh"
module priority_interrupt_module
(
	input wire logic core_clk,
	input wire logic reset_n,
	// Shared bus, three-signal form
	input wire logic [15:0] shared_bus_bits_in,
	output logic [15:0] shared_bus_bits_out,
	output logic shared_bus_bits_oe,
	// Bus strobes and control from the CPU
	input wire logic function_ready_strobe,
	input wire logic data_ready_strobe,
	input wire logic interrupt_acknowledge,
	input wire logic interrupt_timing_clock,
	input wire logic jump_mark_inhibit,
	input wire logic system_reset_in,
	input wire logic run_mode_entered,
	input wire logic execute_cmd_active,
	// Priority chain
	input wire logic priority_chain_in,
	output logic priority_chain_out,
	// Request to the CPU
	output logic interrupt_request_out,
	// Peripheral lines, bit 0 is line zero
	input wire logic [7:0] line_request,
	// Backplane straps and jumpers
	input wire logic vector_base_strap_a,
	input wire logic vector_base_strap_b,
	input wire logic vector_base_strap_c,
	input wire logic [2:0] device_addr_jumper
);

	// Registered state and its next value
	pim_pkg::st_t state_r;
	pim_pkg::st_t state_nxt;
	// Raw pin bundle
	pim_pkg::pins_t pins;
	// Edge events seen on the synchronised pins
	logic fry_rise;
	logic dry_rise;
	logic ack_rise;
	logic ack_fall;
	logic iuc_fall;
	logic jmp_rise;
	// Command decode results
	logic dev_hit;
	logic grp_hit;
	logic [2:0] op;
	logic [2:0] fn;
	// Request permission and pending updates
	logic allow;
	logic [7:0] set_pend;
	logic [7:0] clr_pend;

	// Lowest set index wins, line zero first
	function automatic logic [2:0] first_set(input logic [7:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 7; i >= 0; i--)
		begin
			if (v[i])
				idx = 3'(i);
		end
		return idx;
	endfunction

	// Gather pins into one bundle for the synchroniser
	always_comb
	begin
		pins.bus = shared_bus_bits_in;
		pins.lines = line_request;
		pins.fry = function_ready_strobe;
		pins.dry = data_ready_strobe;
		pins.ack = interrupt_acknowledge;
		pins.iuc = interrupt_timing_clock;
		pins.jmp = jump_mark_inhibit;
		pins.pri_in = priority_chain_in;
		pins.sysrst = system_reset_in;
		pins.run = run_mode_entered;
		pins.exec = execute_cmd_active;
		pins.strap = {vector_base_strap_a, vector_base_strap_b,
			vector_base_strap_c};
		pins.jumper = device_addr_jumper;
	end

	// All next-state logic
	always_comb
	begin
		state_nxt = state_r;
		// Two flops before use; s1 feeds only s2
		state_nxt.s1 = pins;
		state_nxt.s2 = state_r.s1;
		state_nxt.s3 = state_r.s2;
		// Edges compare the second stage against the third
		fry_rise = state_r.s2.fry & ~state_r.s3.fry;
		dry_rise = state_r.s2.dry & ~state_r.s3.dry;
		ack_rise = state_r.s2.ack & ~state_r.s3.ack;
		ack_fall = ~state_r.s2.ack & state_r.s3.ack;
		// Trailing edge of the interrupt clock times requests
		iuc_fall = ~state_r.s2.iuc & state_r.s3.iuc;
		jmp_rise = state_r.s2.jmp & ~state_r.s3.jmp;
		// Device address 04X, X from jumpers
		dev_hit = state_r.s2.bus[5:0] ==
			{`PIM_DEV_HI, state_r.s2.jumper};
		grp_hit = state_r.s2.bus[15:12] == `PIM_GRP_HI;
		op = state_r.s2.bus[11:9];
		fn = state_r.s2.bus[8:6];
		// Request needs enable, run mode, no execute, free chain
		allow = state_r.enable & state_r.s2.run
			& ~state_r.s2.exec
			& state_r.s2.pri_in;
		set_pend = 8'h00;
		clr_pend = 8'h00;
		state_nxt.bus_oe = 1'b0;

		// CPU command cycle: function ready with no acknowledge
		if (fry_rise && !state_r.s2.ack && dev_hit && grp_hit)
		begin
			if (op == `PIM_OP_EXC)
			begin
				// Clear and enable or disable may combine
				if (fn[`PIM_FN_CLR])
					clr_pend = 8'hff;
				if (fn[`PIM_FN_EN])
					state_nxt.enable = 1'b1;
				if (fn[`PIM_FN_DIS])
					state_nxt.enable = 1'b0;
			end
			else if (op == `PIM_OP_XFER && fn <= `PIM_FN_LAST_XFER)
			begin
				// Memory, A or B source looks alike here
				state_nxt.dto = 1'b1;
			end
		end

		// Data ready carries the mask word and ends the transfer
		if (dry_rise)
		begin
			if (state_r.dto)
				state_nxt.mask = state_r.s2.bus[7:0];
			state_nxt.dto = 1'b0;
		end

		// Line scan on a fixed period from the core clock
		if (state_r.scan_cnt == 8'(`PIM_SCAN_CYC - 1))
		begin
			state_nxt.scan_cnt = 8'h00;
			state_nxt.line_prev = state_r.s2.lines;
			// Only a false-to-true change counts; mask blocks it
			set_pend = state_r.s2.lines & ~state_r.line_prev
				& ~state_r.mask;
		end
		else
		begin
			state_nxt.scan_cnt = state_r.scan_cnt + 8'h01;
		end

		// Jump-and-mark shuts the module off until software
		if (jmp_rise)
			state_nxt.enable = 1'b0;

		// Request and acknowledge sequence
		case (state_r.state)
			pim_pkg::ST_IDLE:
			begin
				state_nxt.req = 1'b0;
				if (iuc_fall && allow && (|state_r.pending))
				begin
					state_nxt.state = pim_pkg::ST_REQ;
					state_nxt.req = 1'b1;
					// Lowest index wins; the rest stay stored
					state_nxt.served = first_set(state_r.pending);
				end
			end
			pim_pkg::ST_REQ:
			begin
				// Withdraw if a higher request or inhibit appears
				if (!allow)
				begin
					state_nxt.state = pim_pkg::ST_IDLE;
					state_nxt.req = 1'b0;
				end
				else if (ack_rise)
				begin
					state_nxt.state = pim_pkg::ST_ACK;
				end
			end
			pim_pkg::ST_ACK:
			begin
				// Drive vector only while both strobes are high
				state_nxt.bus_oe = state_r.s2.fry & state_r.s2.ack;
				// Base from straps, line code above a zero bit
				state_nxt.bus_out = {9'h000, state_r.s2.strap,
					state_r.served,
					1'b0};
				if (ack_fall)
				begin
					clr_pend[state_r.served] = 1'b1;
					state_nxt.state = pim_pkg::ST_IDLE;
					state_nxt.req = 1'b0;
					state_nxt.bus_oe = 1'b0;
				end
			end
			default:
			begin
				state_nxt.state = pim_pkg::ST_IDLE;
				state_nxt.req = 1'b0;
			end
		endcase

		// A new edge beats a clear in the same cycle
		state_nxt.pending = (state_r.pending & ~clr_pend) | set_pend;

		// System reset clears control but never the mask
		if (state_r.s2.sysrst)
		begin
			state_nxt.enable = 1'b0;
			state_nxt.dto = 1'b0;
			state_nxt.pending = 8'h00;
			state_nxt.state = pim_pkg::ST_IDLE;
			state_nxt.req = 1'b0;
			state_nxt.bus_oe = 1'b0;
		end

		// Chain passes only when nothing of ours is in flight
		state_nxt.pri_out = state_r.s2.pri_in & ~state_nxt.req
			& (state_nxt.state != pim_pkg::ST_ACK);
	end

	// Single state register; reset loads constants only
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r <= '0;
			state_r.mask <= `PIM_MASK_RST;
			state_r.state <= pim_pkg::ST_IDLE;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// Outputs straight from flops
	assign shared_bus_bits_out = state_r.bus_out;
	assign shared_bus_bits_oe = state_r.bus_oe;
	assign interrupt_request_out = state_r.req;
	assign priority_chain_out = state_r.pri_out;

	// Checks on the running design
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	// Acknowledge cycle from the CPU side
	sequence ack_start;
		state_r.state == pim_pkg::ST_REQ && ack_rise && allow;
	endsequence
	sequence ack_taken;
		state_r.state == pim_pkg::ST_ACK;
	endsequence

	a_ack_enter: assert property (ack_start |=> ack_taken)
		else $error("acknowledge not taken");
	a_vec_even: assert property (shared_bus_bits_oe
		|-> shared_bus_bits_out[0] == 1'b0)
		else $error("vector address odd");
	a_vec_line: assert property (shared_bus_bits_oe
		|-> shared_bus_bits_out[3:1] == state_r.served)
		else $error("vector line code wrong");
	a_run_gate: assert property ($rose(interrupt_request_out)
		|-> $past(state_r.s2.run) && $past(state_r.enable))
		else $error("request raised outside run or enable");
	a_exec_gate: assert property (state_r.s2.exec
		&& state_r.state != pim_pkg::ST_ACK
		|=> !interrupt_request_out)
		else $error("request during execute");
	a_mask_keep: assert property (state_r.s2.sysrst && !dry_rise
		|=> state_r.mask == $past(state_r.mask))
		else $error("system reset changed mask");
	a_dto_reset: assert property (dry_rise |=> !state_r.dto)
		else $error("transfer flop not reset");
	a_jump_clear: assert property (jmp_rise && !state_r.s2.sysrst
		|=> !state_r.enable)
		else $error("jump-and-mark left module enabled");
	a_chain_block: assert property (!state_r.s2.pri_in
		|=> !priority_chain_out && !interrupt_request_out)
		else $error("chain not blocked");
	a_req_hold: assert property (state_r.state == pim_pkg::ST_REQ
		&& allow && !state_r.s2.sysrst |=> interrupt_request_out)
		else $error("request level dropped");
	a_scan_period: assert property (state_r.scan_cnt
		< 8'(`PIM_SCAN_CYC))
		else $error("scan counter overran");
	a_served_top: assert property ($rose(interrupt_request_out)
		|-> state_r.served == first_set($past(state_r.pending)))
		else $error("lower line served first");
	a_mask_block: assert property (state_r.scan_cnt == 8'h00
		|-> (state_r.pending & ~$past(state_r.pending)
		& $past(state_r.mask)) == 8'h00)
		else $error("masked line stored");

	// Control command to this module, no system reset pending
	sequence exc_seen;
		fry_rise && !state_r.s2.ack && dev_hit && grp_hit
			&& op == `PIM_OP_EXC && !state_r.s2.sysrst;
	endsequence

	// Enable alone; jump-and-mark in the same cycle would win
	a_exc_enable: assert property (exc_seen ##0 (fn == 3'h2 && !jmp_rise)
		|=> state_r.enable)
		else $error("enable command ignored");
	// Disable beats enable when both bits are set
	a_exc_disable: assert property (exc_seen ##0 fn[`PIM_FN_DIS]
		|=> !state_r.enable)
		else $error("disable command ignored");
	// Clear empties storage unless a scan lands in the same cycle
	a_exc_clear: assert property (exc_seen ##0 (fn[`PIM_FN_CLR]
		&& state_r.scan_cnt != 8'(`PIM_SCAN_CYC - 1))
		|=> state_r.pending == 8'h00)
		else $error("clear command left requests");
	// Every unmasked rising line is stored at its scan
	a_edge_store: assert property (!state_r.s2.sysrst
		&& state_r.scan_cnt == 8'(`PIM_SCAN_CYC - 1)
		|=> (~state_r.pending & $past(state_r.s2.lines)
		& ~$past(state_r.line_prev) & ~$past(state_r.mask)) == 8'h00)
		else $error("rising line not stored");
	// System reset drops request, bus drive, enable and storage
	a_sysrst_idle: assert property (state_r.s2.sysrst
		|=> !interrupt_request_out && !shared_bus_bits_oe
		&& !state_r.enable && state_r.pending == 8'h00)
		else $error("system reset left control active");
	// The vector is driven only inside an acknowledge cycle
	a_oe_in_ack: assert property (shared_bus_bits_oe
		|-> state_r.state == pim_pkg::ST_ACK)
		else $error("bus driven outside acknowledge");
	// A disabled module never starts a request
	a_disabled_quiet: assert property (!state_r.enable
		&& state_r.state == pim_pkg::ST_IDLE
		|=> !interrupt_request_out)
		else $error("request raised while disabled");

endmodule

// *** tb/cpu_model.sv ***
`timescale 1ns/1ns
// CPU side of the I/O bus: commands, data words, acknowledge
module cpu_model
#(
	parameter logic [2:0] JUMPER = 3'h0 // Device digit
)
(
	input wire logic core_clk,
	input wire logic [15:0] dev_out,
	input wire logic dev_oe,
	output logic [15:0] bus_wire,
	output logic fry,
	output logic dry,
	output logic ack,
	output logic iuc
);
	logic [15:0] drv_r; // Word the CPU drives
	logic drv_oe_r; // CPU owns the bus
	logic [15:0] last_r; // Last bus level
	logic [5:0] div_r; // Interrupt clock divider
	// No pull on the bus: a released bus toggles, never a stale word
	assign bus_wire = dev_oe ? dev_out : (drv_oe_r ? drv_r : ~last_r);
	// About 1.1 MHz, forced high during acknowledge
	assign iuc = ack | (div_r < 6'd23);
	// Divider restarts under acknowledge, so no early trailing edge
	always @(posedge core_clk)
	begin
		last_r <= bus_wire;
		div_r <= (ack || div_r == 6'd44) ? 6'd0 : div_r + 6'd1;
	end
	// Quiet bus at time zero
	initial
	begin
		drv_r = 16'h0000;
		drv_oe_r = 1'b0;
		last_r = 16'h0000;
		div_r = 6'd0;
		fry = 1'b0;
		dry = 1'b0;
		ack = 1'b0;
	end
	// One strobed word; data strobe for data, function strobe else
	task automatic put(input logic is_data, input logic [15:0] w);
		@(posedge core_clk);
		drv_r <= w;
		drv_oe_r <= 1'b1;
		fry <= ~is_data;
		dry <= is_data;
		repeat (5) @(posedge core_clk);
		fry <= 1'b0;
		dry <= 1'b0;
		drv_oe_r <= 1'b0;
		// Idle gap leaves room for a request
		repeat (5) @(posedge core_clk);
	endtask
	// Device command: group 8, op, function, address 04X
	task automatic cmd(input logic [2:0] op, input logic [2:0] fn);
		put(1'b0, {4'h8, op, fn, 3'h4, JUMPER});
	endtask
	// Mask load: transfer command, then the data word
	task automatic mask(input logic [2:0] fn, input logic [7:0] m);
		cmd(3'h3, fn);
		put(1'b1, {8'h00, m});
	endtask
	// Acknowledge, then read the vector once the module drives
	task automatic serve(output logic [15:0] vec, output logic ok);
		int n;
		@(posedge core_clk);
		ack <= 1'b1;
		repeat (5) @(posedge core_clk);
		fry <= 1'b1;
		ok = 1'b0;
		vec = 16'h0000;
		for (n = 0; n < 20 && ok !== 1'b1; n++)
		begin
			@(negedge core_clk);
			ok = dev_oe;
			vec = bus_wire;
		end
		@(posedge core_clk);
		fry <= 1'b0;
		ack <= 1'b0;
		repeat (6) @(negedge core_clk);
	endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ns
// Lines and CPU status driven here, bus traffic by the CPU model
module testbench;
	logic core_clk; // Core clock
	logic reset_n; // Power-on reset
	logic [15:0] bw, bo; // Resolved bus, module drive
	logic oe, fry, dry, ack, iuc, req, po; // Bus and request pins
	logic jmp, srst, run, exe, pin; // CPU status
	logic [7:0] ln; // Peripheral lines
	logic [15:0] v; // Vector read back
	logic ok; // Acknowledge done in time
	int err_count;
	int tests_run;
	// 50 MHz clock
	always #10 core_clk = ~core_clk;
	priority_interrupt_module priority_interrupt_module_inst
	(
		.core_clk(core_clk),
		.reset_n(reset_n),
		.shared_bus_bits_in(bw),
		.shared_bus_bits_out(bo),
		.shared_bus_bits_oe(oe),
		.function_ready_strobe(fry),
		.data_ready_strobe(dry),
		.interrupt_acknowledge(ack),
		.interrupt_timing_clock(iuc),
		.jump_mark_inhibit(jmp),
		.system_reset_in(srst),
		.run_mode_entered(run),
		.execute_cmd_active(exe),
		.priority_chain_in(pin),
		.priority_chain_out(po),
		.interrupt_request_out(req),
		.line_request(ln),
		.vector_base_strap_a(1'b1),
		.vector_base_strap_b(1'b0),
		.vector_base_strap_c(1'b0),
		.device_addr_jumper(3'h0)
	);
	cpu_model cpu_model_inst
	(
		.core_clk(core_clk),
		.dev_out(bo),
		.dev_oe(oe),
		.bus_wire(bw),
		.fry(fry),
		.dry(dry),
		.ack(ack),
		.iuc(iuc)
	);
	// Four-state compare, counted
	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
			err_count++;
		end
	endtask
	// Verdict and end of run
	task automatic tally_and_finish();
		if (err_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Edge held past one 900 ns scan, then dropped
	task automatic rise(input logic [7:0] l);
		@(posedge core_clk);
		ln <= l;
		repeat (100) @(posedge core_clk);
		ln <= 8'h00;
		repeat (60) @(posedge core_clk);
	endtask
	// Bounded wait for a request; any request seen is served
	task automatic want(input logic e, input logic [15:0] vec);
		int n;
		@(negedge core_clk);
		for (n = 0; n < 200 && req !== 1'b1; n++)
			@(negedge core_clk);
		chk("request", {15'h0, req}, {15'h0, e});
		if (req === 1'b1)
		begin
			chk("chain_busy", {15'h0, po}, 16'h0);
			cpu_model_inst.serve(v, ok);
			if (ok !== 1'b1)
			begin
				err_count++;
				tally_and_finish();
			end
			chk("vector", v, vec);
			chk("req_drop", {15'h0, req}, 16'h0);
			chk("chain_free", {15'h0, po}, 16'h1);
		end
	endtask
	initial
	begin
		int k;
		core_clk = 1'b0;
		reset_n = 1'b0;
		jmp = 1'b0;
		srst = 1'b0;
		run = 1'b1;
		exe = 1'b0;
		pin = 1'b1;
		ln = 8'h00;
		err_count = 0;
		tests_run = 0;
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (4) @(negedge core_clk);
		chk("rst_req", {15'h0, req}, 16'h0);
		chk("rst_oe", {15'h0, oe}, 16'h0);
		cpu_model_inst.cmd(3'h0, 3'h1);
		cpu_model_inst.cmd(3'h0, 3'h3);
		// Each transfer code opens one line; a lone data word loads nothing
		for (k = 0; k < 3; k++)
		begin
			cpu_model_inst.mask(k[2:0], ~(8'h01 << k));
			cpu_model_inst.put(1'b1, 16'h0000);
			rise(8'hff);
			want(1'b1, 16'h0040 | (16'(k) << 1));
			want(1'b0, 16'h0000);
		end
		// Two lines at once: higher first, lower kept
		cpu_model_inst.mask(3'h1, 8'h00);
		rise(8'h05);
		want(1'b1, 16'h0040);
		want(1'b1, 16'h0044);
		want(1'b0, 16'h0000);
		// System reset drops enable but keeps the mask
		cpu_model_inst.mask(3'h2, 8'h01);
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		rise(8'h03);
		want(1'b0, 16'h0000);
		cpu_model_inst.cmd(3'h0, 3'h2);
		want(1'b1, 16'h0042);
		want(1'b0, 16'h0000);
		// Not in run, executing, chain busy: request held back
		for (k = 0; k < 3; k++)
		begin
			@(posedge core_clk);
			run <= (k != 0);
			exe <= (k == 1);
			pin <= (k != 2);
			rise(8'h08);
			want(1'b0, 16'h0000);
			@(posedge core_clk);
			run <= 1'b1;
			exe <= 1'b0;
			pin <= 1'b1;
			want(1'b1, 16'h0046);
		end
		// Jump-and-mark closes the module until re-enabled
		@(posedge core_clk);
		jmp <= 1'b1;
		repeat (5) @(posedge core_clk);
		jmp <= 1'b0;
		rise(8'h10);
		want(1'b0, 16'h0000);
		cpu_model_inst.cmd(3'h0, 3'h5);
		cpu_model_inst.cmd(3'h0, 3'h2);
		want(1'b0, 16'h0000);
		cpu_model_inst.cmd(3'h0, 3'h4);
		rise(8'h20);
		want(1'b0, 16'h0000);
		cpu_model_inst.cmd(3'h0, 3'h2);
		want(1'b1, 16'h004a);
		tally_and_finish();
	end
endmodule
